// *** rtl/ehl_pkg.sv ***
// Package for the error history logger: record layout, capacities, codes and timing.
// Assumes a single 100 MHz clock domain and a synchronous active-low reset.
package ehl_pkg;

  // ************************************************************
  // Table sizing and record layout
  // ************************************************************
  localparam int unsigned LEGACY_DEPTH = 20;
  localparam int unsigned V1_DEPTH     = 100;
  localparam int unsigned PTR_W        = 7;
  localparam int unsigned STATUS_W     = 16;
  localparam int unsigned TIME_W       = 24;
  localparam int unsigned NODE_W       = 8;
  localparam int unsigned REC_W        = STATUS_W + TIME_W + NODE_W;
  localparam logic [PTR_W-1:0] LEGACY_CAP = 7'h14;
  localparam logic [PTR_W-1:0] V1_CAP     = 7'h64;

  // Record field positions.
  localparam int unsigned NODE_LSB   = 0;
  localparam int unsigned TIME_LSB   = NODE_W;
  localparam int unsigned STATUS_LSB = NODE_W + TIME_W;

  // Alarm detail byte index that carries the node address or response value.
  localparam logic [3:0] DETAIL_NODE_BYTE = 4'h7;

  // ************************************************************
  // Cause codes and display codes
  // ************************************************************
  localparam logic [STATUS_W-1:0] ST_IN_SUPPLY_LOW  = 16'h0004;
  localparam logic [STATUS_W-1:0] ST_OUT_SUPPLY_LOW = 16'h0005;
  localparam logic [STATUS_W-1:0] ST_SWITCH_MISM    = 16'h0010;
  localparam logic [7:0] INPUT_SUPPLY_LOW_CODE  = 8'h04;
  localparam logic [7:0] OUTPUT_SUPPLY_LOW_CODE = 8'h05;
  localparam logic [7:0] DISP_NONE              = 8'h00;

  // ************************************************************
  // Operating time step
  // ************************************************************
  localparam longint unsigned STEP_MIN   = 6;
  localparam longint unsigned CLK_HZ     = 100000000;
  localparam longint unsigned STEP_CYCLES = STEP_MIN * 64'd60 * CLK_HZ;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    EHL_S_RESTORE = 5'h01,
    EHL_S_IDLE    = 5'h02,
    EHL_S_READ    = 5'h04,
    EHL_S_CLEAR   = 5'h08,
    EHL_S_WAIT    = 5'h10
  } ehl_state_t;

endpackage : ehl_pkg

// *** rtl/ehl_ram.sv ***
// Record memory for the error history table, one write and one registered read port.
// Assumes the owner keeps addresses below the depth.
`timescale 1ns/100ps
module ehl_ram (
  input  wire logic                         mclk,
  input  wire logic                         we,
  input  wire logic [ehl_pkg::PTR_W-1:0]    waddr,
  input  wire logic [ehl_pkg::REC_W-1:0]    wdata,
  input  wire logic [ehl_pkg::PTR_W-1:0]    raddr,
  output      logic [ehl_pkg::REC_W-1:0]    rdata
);

  logic [ehl_pkg::REC_W-1:0] mem [ehl_pkg::V1_DEPTH];

  // Write on strobe; read data always comes from a register.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : ehl_ram

// *** rtl/ehl_logger.sv ***
// Error history logger: ring table of records, critical copy to nonvolatile store,
// restore at power-up, remote read and clear, operating time counter.
// Assumes a nonvolatile store with a one-cycle write and read handshake.
`timescale 1ns/100ps
module ehl_logger #(
  parameter longint unsigned STEP_CYCLES = ehl_pkg::STEP_CYCLES
) (
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  input  wire logic                           gen_v1,
  input  wire logic                           err_valid,
  input  wire logic [ehl_pkg::STATUS_W-1:0]   err_status,
  input  wire logic [ehl_pkg::NODE_W-1:0]     err_node,
  input  wire logic                           err_critical,
  input  wire logic                           input_power_ok,
  input  wire logic                           input_terms_used,
  input  wire logic                           output_power_ok,
  input  wire logic                           output_terms_used,
  input  wire logic [ehl_pkg::NODE_W-1:0]     node_switch,
  input  wire logic [ehl_pkg::NODE_W-1:0]     node_configured,
  input  wire logic                           ctrl_reset_cmd,
  input  wire logic [ehl_pkg::TIME_W-1:0]     time_restore,
  input  wire logic                           rd_req,
  input  wire logic [ehl_pkg::PTR_W-1:0]      rd_index,
  input  wire logic                           clr_req,
  output      logic                           rd_valid,
  output      logic [ehl_pkg::STATUS_W-1:0]   rd_status,
  output      logic [ehl_pkg::TIME_W-1:0]     rd_time,
  output      logic [63:0]                    rd_detail,
  output      logic [ehl_pkg::PTR_W-1:0]      rec_count,
  output      logic [ehl_pkg::TIME_W-1:0]     op_time,
  output      logic                           busy,
  output      logic [7:0]                     disp_code,
  output      logic [ehl_pkg::NODE_W-1:0]     disp_node,
  output      logic                           io_leds_off,
  output      logic                           nv_wr,
  output      logic [ehl_pkg::REC_W-1:0]      nv_wdata,
  output      logic                           nv_clr,
  output      logic                           nv_rd,
  input  wire logic                           nv_rd_valid,
  input  wire logic                           nv_rd_last,
  input  wire logic [ehl_pkg::REC_W-1:0]      nv_rdata
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    ehl_pkg::ehl_state_t              st;
    logic [ehl_pkg::PTR_W-1:0]        wptr;
    logic [ehl_pkg::PTR_W-1:0]        cnt;
    logic [63:0]                      step;
    logic [ehl_pkg::TIME_W-1:0]       optime;
    logic                             rd_pend;
    logic                             rd_valid;
    logic [ehl_pkg::REC_W-1:0]        rd_rec;
    logic                             nv_wr;
    logic [ehl_pkg::REC_W-1:0]        nv_wdata;
    logic                             nv_clr;
    logic                             nv_rd;
    logic                             in_low;
    logic                             out_low;
    logic                             sw_mism;
    logic [7:0]                       disp;
    logic                             restore_done;
    logic [ehl_pkg::TIME_W-1:0]       optime_base;
  } ehl_regs_t;

  ehl_regs_t q;
  ehl_regs_t d;

  logic                          ram_we;
  logic [ehl_pkg::PTR_W-1:0]     ram_waddr;
  logic [ehl_pkg::REC_W-1:0]     ram_wdata;
  logic [ehl_pkg::PTR_W-1:0]     ram_raddr;
  logic [ehl_pkg::REC_W-1:0]     ram_rdata;
  logic [ehl_pkg::PTR_W-1:0]     cap;
  logic                          in_low_now;
  logic                          out_low_now;
  logic                          mism_now;
  logic                          log_go;
  logic [ehl_pkg::STATUS_W-1:0]  log_status;
  logic [ehl_pkg::NODE_W-1:0]    log_node;
  logic                          log_crit;

  // Advances a ring pointer, wrapping at the active capacity.
  function automatic logic [ehl_pkg::PTR_W-1:0] ptr_next(
    input logic [ehl_pkg::PTR_W-1:0] p,
    input logic [ehl_pkg::PTR_W-1:0] c
  );
    ptr_next = (p == c - 7'h01) ? 7'h00 : p + 7'h01;
  endfunction : ptr_next

  // Saturating record count.
  function automatic logic [ehl_pkg::PTR_W-1:0] cnt_next(
    input logic [ehl_pkg::PTR_W-1:0] n,
    input logic [ehl_pkg::PTR_W-1:0] c
  );
    cnt_next = (n >= c) ? c : n + 7'h01;
  endfunction : cnt_next

  // ************************************************************
  // Record memory
  // ************************************************************
  ehl_ram u_ram (
    .mclk  (mclk),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  // Supply and switch causes; each logs on a rising condition met in idle with no clear request; of several rising together only the first logs.
  always_comb begin
    cap         = gen_v1 ? ehl_pkg::V1_CAP : ehl_pkg::LEGACY_CAP;
    in_low_now  = !input_power_ok && input_terms_used;
    out_low_now = !output_power_ok && output_terms_used;
    mism_now    = (node_switch != node_configured);
    log_go      = 1'b0;
    log_status  = err_status;
    log_node    = err_node;
    log_crit    = err_critical;
    // Internal causes take priority over an external error in the same cycle.
    if (in_low_now && !q.in_low) begin
      log_go     = 1'b1;
      log_status = ehl_pkg::ST_IN_SUPPLY_LOW;
      log_node   = node_switch;
      log_crit   = gen_v1;
    end else if (out_low_now && !q.out_low) begin
      log_go     = 1'b1;
      log_status = ehl_pkg::ST_OUT_SUPPLY_LOW;
      log_node   = node_switch;
      log_crit   = gen_v1;
    end else if (mism_now && !q.sw_mism) begin
      log_go     = 1'b1;
      log_status = ehl_pkg::ST_SWITCH_MISM;
      log_node   = node_switch;
      log_crit   = 1'b1;
    end else if (err_valid) begin
      log_go     = 1'b1;
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    d           = q;
    d.nv_wr     = 1'b0;
    d.nv_clr    = 1'b0;
    d.nv_rd     = 1'b0;
    d.rd_valid  = 1'b0;
    d.rd_pend   = 1'b0;
    d.in_low    = in_low_now;
    d.out_low   = out_low_now;
    d.sw_mism   = mism_now;
    ram_we      = 1'b0;
    ram_waddr   = q.wptr;
    // Stamp carries the accumulated time, retained base included.
    ram_wdata   = {log_status, op_time, log_node};
    ram_raddr   = rd_index;
    // Display shows the supply code while either supply condition stands.
    d.disp      = in_low_now ? ehl_pkg::INPUT_SUPPLY_LOW_CODE :
                  out_low_now ? ehl_pkg::OUTPUT_SUPPLY_LOW_CODE :
                  ehl_pkg::DISP_NONE;
    // Operating time: one unit per step while powered; reset command zeroes it.
    if (ctrl_reset_cmd) begin
      d.optime = '0;
      d.step   = '0;
    end else if (q.step == STEP_CYCLES - 64'd1) begin
      d.step   = '0;
      d.optime = q.optime + 24'h000001;
    end else begin
      d.step   = q.step + 64'd1;
    end
    // Retained time is taken once after reset release; the reset command drops it.
    if (!q.restore_done) begin
      d.restore_done = 1'b1;
      d.optime_base  = time_restore;
    end else if (ctrl_reset_cmd) begin
      d.optime_base  = '0;
    end
    case (q.st)
      ehl_pkg::EHL_S_RESTORE: begin
        // Copy nonvolatile history into the ring before logging starts.
        d.nv_rd = 1'b1;
        if (nv_rd_valid) begin
          ram_we    = 1'b1;
          ram_wdata = nv_rdata;
          d.wptr    = ptr_next(q.wptr, cap);
          d.cnt     = cnt_next(q.cnt, cap);
        end
        if (nv_rd_last) begin
          d.st    = ehl_pkg::EHL_S_IDLE;
          d.nv_rd = 1'b0;
        end
      end
      ehl_pkg::EHL_S_IDLE: begin
        if (clr_req) begin
          d.st     = ehl_pkg::EHL_S_CLEAR;
          d.wptr   = '0;
          d.cnt    = '0;
          d.nv_clr = 1'b1;
        end else if (log_go) begin
          ram_we = 1'b1;
          d.wptr = ptr_next(q.wptr, cap);
          d.cnt  = cnt_next(q.cnt, cap);
          if (log_crit) begin
            d.nv_wr    = 1'b1;
            d.nv_wdata = ram_wdata;
          end
        end else if (rd_req) begin
          d.rd_pend = 1'b1;
          d.st      = ehl_pkg::EHL_S_READ;
        end
      end
      ehl_pkg::EHL_S_READ: begin
        d.rd_valid = 1'b1;
        d.rd_rec   = ram_rdata;
        d.st       = ehl_pkg::EHL_S_IDLE;
      end
      ehl_pkg::EHL_S_CLEAR: begin
        d.st = ehl_pkg::EHL_S_WAIT;
      end
      ehl_pkg::EHL_S_WAIT: begin
        d.st = ehl_pkg::EHL_S_IDLE;
      end
      default: begin
        d.st = ehl_pkg::EHL_S_IDLE;
      end
    endcase
  end

  // Register stage; reset clears every field and starts the restore sequence.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      q       <= '0;
      q.st    <= ehl_pkg::EHL_S_RESTORE;
      q.optime <= '0;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rd_valid    = q.rd_valid;
  assign rd_status   = q.rd_rec[ehl_pkg::STATUS_LSB +: ehl_pkg::STATUS_W];
  assign rd_time     = q.rd_rec[ehl_pkg::TIME_LSB +: ehl_pkg::TIME_W];
  // Node value sits in byte 7 of the detail word, status in the low bytes.
  assign rd_detail   = {q.rd_rec[ehl_pkg::NODE_LSB +: ehl_pkg::NODE_W],
                        40'h0, q.rd_rec[ehl_pkg::STATUS_LSB +: ehl_pkg::STATUS_W]};
  assign rec_count   = q.cnt;
  assign op_time     = q.optime + q.optime_base;
  assign busy        = (q.st != ehl_pkg::EHL_S_IDLE);
  assign disp_code   = q.disp;
  assign disp_node   = node_switch;
  assign io_leds_off = (q.disp != ehl_pkg::DISP_NONE);
  assign nv_wr       = q.nv_wr;
  assign nv_wdata    = q.nv_wdata;
  assign nv_clr      = q.nv_clr;
  assign nv_rd       = q.nv_rd;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_count_saturates: assert property (@(posedge mclk) disable iff (!reset_n)
    q.cnt <= (gen_v1 ? ehl_pkg::V1_CAP : ehl_pkg::LEGACY_CAP) || $changed(gen_v1))
    else $error("Record count above capacity.");
  a_legacy_wrap: assert property (@(posedge mclk) disable iff (!reset_n)
    (!gen_v1 && q.st == ehl_pkg::EHL_S_IDLE && !clr_req && log_go && q.wptr == 7'h13)
    |=> q.wptr == 7'h00)
    else $error("Legacy ring did not wrap at 20.");
  a_log_writes: assert property (@(posedge mclk) disable iff (!reset_n)
    (q.st == ehl_pkg::EHL_S_IDLE && !clr_req && log_go) |-> ram_we)
    else $error("Error not written to table.");
  a_crit_to_nv: assert property (@(posedge mclk) disable iff (!reset_n)
    (q.st == ehl_pkg::EHL_S_IDLE && !clr_req && log_go && log_crit) |=> nv_wr)
    else $error("Critical error not stored nonvolatile.");
  a_clear_both: assert property (@(posedge mclk) disable iff (!reset_n)
    (q.st == ehl_pkg::EHL_S_IDLE && clr_req) |=> (nv_clr && rec_count == 7'h00))
    else $error("Clear did not erase both stores.");
  a_read_answer: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(q.rd_pend) |=> rd_valid)
    else $error("Read not answered in two cycles.");
  a_reset_time: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_reset_cmd && q.restore_done |=> op_time == '0)
    else $error("Reset command did not clear time.");
  a_legacy_supply: assert property (@(posedge mclk) disable iff (!reset_n)
    (!gen_v1 && in_low_now && !q.in_low) |-> !log_crit)
    else $error("Legacy supply-low marked for storage.");
  a_supply_disp: assert property (@(posedge mclk) disable iff (!reset_n)
    in_low_now |=> (disp_code == ehl_pkg::INPUT_SUPPLY_LOW_CODE && io_leds_off))
    else $error("Input supply-low not displayed.");
  a_restore_first: assert property (@(posedge mclk) disable iff (!reset_n)
    (q.st == ehl_pkg::EHL_S_RESTORE) |-> (!nv_wr && (!ram_we || nv_rd_valid)))
    else $error("Logging before restore finished.");

  c_wrap_v1: cover property (@(posedge mclk) gen_v1 && q.cnt == ehl_pkg::V1_CAP && ram_we);
  c_read:    cover property (@(posedge mclk) rd_valid);
  c_clear:   cover property (@(posedge mclk) nv_clr);
  c_mism:    cover property (@(posedge mclk) mism_now && !q.sw_mism);

endmodule : ehl_logger

// *** sim/ehl_nv_model.sv ***
// Behavioural nonvolatile history store facing the logger.
// Assumes it is never reset: contents survive a logger reset, as over a power cycle.
`timescale 1ns/100ps
module ehl_nv_model (
  input  wire logic                      mclk,
  input  wire logic                      nv_wr,
  input  wire logic [ehl_pkg::REC_W-1:0] nv_wdata,
  input  wire logic                      nv_clr,
  input  wire logic                      nv_rd,
  output      logic                      nv_rd_valid,
  output      logic                      nv_rd_last,
  output      logic [ehl_pkg::REC_W-1:0] nv_rdata,
  output      logic [7:0]                nv_cnt
);
  // ************************************************************
  // Storage and restore playback
  // ************************************************************
  logic [ehl_pkg::REC_W-1:0] mem [0:127];
  logic [7:0]                idx;

  // Start empty with the return lines quiet.
  initial begin
    nv_cnt = 8'h00;
    idx = 8'h00;
    nv_rd_valid = 1'b0;
    nv_rd_last = 1'b0;
    nv_rdata = '0;
  end

  // Keep records in arrival order and play them back one per cycle while the read is open.
  always @(posedge mclk) begin
    if (nv_clr) begin
      nv_cnt <= 8'h00;
    end else if (nv_wr && nv_cnt < 8'h80) begin
      mem[nv_cnt[6:0]] <= nv_wdata;
      nv_cnt <= nv_cnt + 8'h01;
    end
    nv_rd_valid <= 1'b0;
    nv_rd_last <= 1'b0;
    nv_rdata <= ~nv_rdata; // Idle data keeps moving so no stale record can pass.
    if (!nv_rd) begin
      idx <= 8'h00;
    end else if (idx != 8'hff) begin
      idx <= idx + 8'h01;
      if (idx < nv_cnt) begin
        nv_rd_valid <= 1'b1;
        nv_rdata <= mem[idx[6:0]];
        nv_rd_last <= (idx + 8'h01 == nv_cnt);
      end else if (nv_cnt == 8'h00 && idx == 8'h00) begin
        nv_rd_last <= 1'b1;
      end
    end
  end
endmodule : ehl_nv_model

// *** sim/tb_top.sv ***
// Self-checking bench for the error history logger with a nonvolatile store model.
// Assumes the logger's hand-over timing; inputs change on falling clock edges.
`timescale 1ns/100ps
module tb_top;
  // ************************************************************
  // Clock, design and store model
  // ************************************************************
  logic mclk = 1'b0, reset_n = 1'b0, gen_v1 = 1'b1, err_valid = 1'b0, err_critical = 1'b0;
  logic input_power_ok = 1'b1, input_terms_used = 1'b1, output_power_ok = 1'b1;
  logic output_terms_used = 1'b1, ctrl_reset_cmd = 1'b0, rd_req = 1'b0, clr_req = 1'b0;
  logic [15:0] err_status = 16'h0000;
  logic [7:0]  err_node = 8'h00, node_switch = 8'h2a, node_configured = 8'h2a;
  logic [7:0]  disp_code, disp_node, nv_cnt;
  logic [23:0] time_restore = 24'h000100, rd_time, op_time, last_tm;
  logic [6:0]  rd_index = 7'h00, rec_count;
  logic [15:0] rd_status;
  logic [63:0] rd_detail;
  logic [47:0] nv_wdata, nv_rdata;
  logic        rd_valid, busy, io_leds_off, nv_wr, nv_clr, nv_rd, nv_rd_valid, nv_rd_last;
  int          mismatches = 0, compares = 0;

  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;

  ehl_logger #(.STEP_CYCLES(10)) u_ehl_logger (.mclk, .reset_n, .gen_v1, .err_valid,
    .err_status, .err_node, .err_critical, .input_power_ok, .input_terms_used,
    .output_power_ok, .output_terms_used, .node_switch, .node_configured, .ctrl_reset_cmd,
    .time_restore, .rd_req, .rd_index, .clr_req, .rd_valid, .rd_status, .rd_time, .rd_detail,
    .rec_count, .op_time, .busy, .disp_code, .disp_node, .io_leds_off, .nv_wr, .nv_wdata,
    .nv_clr, .nv_rd, .nv_rd_valid, .nv_rd_last, .nv_rdata);

  ehl_nv_model u_ehl_nv_model (.mclk, .nv_wr, .nv_wdata, .nv_clr, .nv_rd, .nv_rd_valid,
    .nv_rd_last, .nv_rdata, .nv_cnt);

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic wait_idle;
    int n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2000) chk(busy, 1'b0, "busy stuck");
  endtask : wait_idle

  task automatic do_reset;
    reset_n = 1'b0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    wait_idle();
  endtask : do_reset

  task automatic count_nv(input int n, output logic [3:0] w);
    w = 4'h0;
    repeat (n) begin
      @(negedge mclk);
      w = w + {3'h0, nv_wr};
    end
  endtask : count_nv

  // Expected count after one logged error: grows by one, holds at the table size.
  function automatic logic [6:0] cnt_after(input logic [6:0] c);
    cnt_after = (c == (gen_v1 ? ehl_pkg::V1_CAP : ehl_pkg::LEGACY_CAP)) ? c : c + 7'h01;
  endfunction : cnt_after

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic log_err(input logic [15:0] st, input logic [7:0] nd, input logic cr);
    logic [6:0] c;
    @(negedge mclk);
    wait_idle();
    c = rec_count;
    last_tm = op_time;
    err_status = st;
    err_node = nd;
    err_critical = cr;
    err_valid = 1'b1;
    @(negedge mclk);
    err_valid = 1'b0;
    chk(nv_wr, cr, "nv write");
    if (cr) chk(nv_wdata, {st, last_tm, nd}, "nv record");
    chk(rec_count, cnt_after(c), "count");
  endtask : log_err

  task automatic read_rec(input logic [6:0] i, input logic [15:0] st, input logic [7:0] nd);
    @(negedge mclk);
    wait_idle();
    rd_index = i;
    rd_req = 1'b1;
    @(negedge mclk);
    rd_req = 1'b0;
    @(negedge mclk);
    chk(rd_valid, 1'b1, "read strobe");
    chk({rd_status, rd_detail[63:56], rd_detail[15:0]}, {st, nd, st}, "read record");
  endtask : read_rec

  task automatic supply_low(input logic inp, input logic exp_nv);
    logic [3:0] w;
    logic [6:0] c;
    @(negedge mclk);
    wait_idle();
    c = rec_count;
    if (inp) input_power_ok = 1'b0;
    else output_power_ok = 1'b0;
    count_nv(4, w);
    chk(rec_count, cnt_after(c), "supply count");
    chk(disp_code, inp ? ehl_pkg::INPUT_SUPPLY_LOW_CODE : ehl_pkg::OUTPUT_SUPPLY_LOW_CODE,
        "display code");
    chk({io_leds_off, disp_node}, {1'b1, node_switch}, "indicators");
    chk(w, exp_nv, "supply nv");
    input_power_ok = 1'b1;
    output_power_ok = 1'b1;
  endtask : supply_low

  task automatic mismatch;
    logic [3:0] w;
    logic [6:0] c;
    @(negedge mclk);
    wait_idle();
    c = rec_count;
    node_configured = 8'h3c;
    count_nv(4, w);
    chk(rec_count, cnt_after(c), "mismatch count");
    chk(w, 1, "mismatch nv");
    node_configured = node_switch;
  endtask : mismatch

  task automatic op_time_test;
    int n = 0;
    logic [23:0] t;
    @(negedge mclk);
    t = op_time;
    while (op_time === t && n < 40) begin @(negedge mclk); n++; end
    t = op_time;
    n = 0;
    while (op_time === t && n < 40) begin @(negedge mclk); n++; end
    chk(n, 10, "step length");
    chk(op_time, t + 24'h000001, "step size");
    ctrl_reset_cmd = 1'b1;
    @(negedge mclk);
    ctrl_reset_cmd = 1'b0;
    repeat (2) @(negedge mclk);
    chk(op_time, 24'h000000, "time zeroed");
  endtask : op_time_test

  task automatic clear_all;
    @(negedge mclk);
    wait_idle();
    clr_req = 1'b1;
    @(negedge mclk);
    clr_req = 1'b0;
    chk({nv_clr, rec_count}, {1'b1, 7'h00}, "clear");
    @(negedge mclk);
    wait_idle();
    chk(nv_cnt, 8'h00, "store emptied");
  endtask : clear_all

  // Main sequence: log, read, restore, time, clear, wrap in both generations.
  initial begin
    do_reset();
    chk(rec_count, 7'h00, "empty start");
    chk(op_time >= 24'h000100, 1'b1, "time base");
    log_err(16'h1234, 8'h21, 1'b0);
    log_err(16'h5678, 8'h42, 1'b1);
    read_rec(7'h00, 16'h1234, 8'h21);
    read_rec(7'h01, 16'h5678, 8'h42);
    chk(rd_time, last_tm, "read time");
    supply_low(1'b1, 1'b1);
    supply_low(1'b0, 1'b1);
    mismatch();
    do_reset();
    chk(rec_count, 7'h04, "restored count");
    read_rec(7'h00, 16'h5678, 8'h42);
    op_time_test();
    clear_all();
    for (int i = 0; i < 101; i++) log_err(16'h0100 + 16'(i), 8'h55, 1'b0);
    chk(rec_count, 7'h64, "large table full");
    read_rec(7'h00, 16'h0164, 8'h55);
    gen_v1 = 1'b0;
    do_reset();
    for (int i = 0; i < 21; i++) log_err(16'h0200 + 16'(i), 8'h55, 1'b0);
    chk(rec_count, 7'h14, "small table full");
    read_rec(7'h00, 16'h0214, 8'h55);
    supply_low(1'b1, 1'b0);
    stop_test();
  end

  // Watchdog: the sequence needs about 400 cycles, so 10000 cycles means a hang.
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule : tb_top
